// file: logic/bal_exec_regs.svh
// Constants for the balance execute, pause and status block
`ifndef BAL_EXEC_REGS_SVH
`define BAL_EXEC_REGS_SVH
`define STATUS_RESET 16'h000F
`define CMD_EXEC_GOOD 8'hAF
`define CMD_EXEC_BAD 8'hAE
`define CMD_OP_EXEC 2'h3
`define CLK_HZ 40000000
`define START_DELAY_US 2000
`define START_DELAY_CYC ((`START_DELAY_US * (`CLK_HZ / 1000000)))
`define CRC_POLY 4'h3
`endif

// file: logic/bal_exec_pkg.sv
// Types for the balance execute, pause and status block
`default_nettype none
package bal_exec_pkg;
  typedef struct packed {
    logic [5:0] gate_ok;
    logic cells_ok;
    logic sec_ok;
    logic temp_ok;
  } health_s;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_ON
  } run_e;
endpackage
`default_nettype wire

// file: logic/balance_execute_pause_status.sv
// Execute, pause and resume handling plus balance status word
`include "bal_exec_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module balance_execute_pause_status #(
  parameter int START_DELAY_CYC = `START_DELAY_CYC
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Serial port pins from the host
  input wire logic i_chip_select_in_n,
  input wire logic i_serial_clock_in,
  input wire logic i_serial_data_in,
  // Latched command from the holding register
  input wire logic [11:0] i_held_cmd,
  input wire logic i_held_valid,
  // Analog health inputs
  input wire bal_exec_pkg::health_s i_health,
  // Balancer drive and status
  output logic [11:0] o_balance_drive,
  output logic o_balancing,
  output logic [15:0] o_balance_status_word
);
  logic [1:0] cs_sync_q;
  logic [1:0] sck_sync_q;
  logic [1:0] sdi_sync_q;
  logic sck_prev_q;
  logic cs_n;
  logic sck_rise;
  logic [7:0] shift_q;
  logic [3:0] bit_cnt_q;
  logic locked_q;
  logic [11:0] run_cmd_q;
  bal_exec_pkg::run_e state_q;
  logic [31:0] dly_q;
  logic byte_done;
  logic [7:0] byte_val;
  logic parity_ok;
  logic is_exec;
  // Good-parity execute byte; only bits 7:1 are compared, the opcode both parities share
  localparam logic [7:0] EXEC_BYTE = `CMD_EXEC_GOOD;

  // Two-stage synchronisers; the host clock is sampled, not used as a clock
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cs_sync_q <= 2'h3;
      sck_sync_q <= 2'h0;
      sdi_sync_q <= 2'h0;
      sck_prev_q <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], i_chip_select_in_n};
      sck_sync_q <= {sck_sync_q[0], i_serial_clock_in};
      sdi_sync_q <= {sdi_sync_q[0], i_serial_data_in};
      sck_prev_q <= sck_sync_q[1];
    end
  end
  assign cs_n = cs_sync_q[1];
  assign sck_rise = sck_sync_q[1] & ~sck_prev_q & ~cs_n;

  // Command byte framing; every byte is a command until an execute byte locks the frame
  assign byte_val = {shift_q[6:0], sdi_sync_q[1]};
  assign byte_done = sck_rise && (bit_cnt_q == 4'h7) && !locked_q;
  // Good bytes carry an even count of ones, as the good execute byte does
  assign parity_ok = ~^byte_val;
  assign is_exec = (byte_val[7:1] == EXEC_BYTE[7:1]);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_q <= 8'h00;
      bit_cnt_q <= 4'h0;
      locked_q <= 1'b0;
    end else if (cs_n) begin
      bit_cnt_q <= 4'h0;
      locked_q <= 1'b0;
    end else if (sck_rise && !locked_q) begin
      shift_q <= byte_val;
      // Count modulo 8 so that every byte boundary of a frame up to the lock is checked
      bit_cnt_q <= (bit_cnt_q == 4'h7) ? 4'h0 : bit_cnt_q + 4'h1;
      if (bit_cnt_q == 4'h7) begin
        locked_q <= is_exec;
      end
    end
  end

  // Run control: execute starts the delay, bad parity pauses
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= bal_exec_pkg::ST_IDLE;
      dly_q <= 32'h0;
      run_cmd_q <= 12'h000;
    end else begin
      case (state_q)
        bal_exec_pkg::ST_IDLE: begin
          if (byte_done && parity_ok && is_exec) begin
            run_cmd_q <= i_held_valid ? i_held_cmd : 12'h000;
            state_q <= bal_exec_pkg::ST_DELAY;
            dly_q <= 32'h0;
          end
        end
        bal_exec_pkg::ST_DELAY, bal_exec_pkg::ST_ON: begin
          if (byte_done && !parity_ok) begin
            state_q <= bal_exec_pkg::ST_IDLE;
          end else if (byte_done && is_exec) begin
            run_cmd_q <= i_held_valid ? i_held_cmd : 12'h000;
            state_q <= bal_exec_pkg::ST_DELAY;
            dly_q <= 32'h0;
          end else if (state_q == bal_exec_pkg::ST_DELAY) begin
            if (dly_q >= 32'(START_DELAY_CYC - 1)) begin
              state_q <= bal_exec_pkg::ST_ON;
            end else begin
              dly_q <= dly_q + 32'h1;
            end
          end
        end
        default: state_q <= bal_exec_pkg::ST_IDLE;
      endcase
    end
  end

  // CRC-4 of the 12 message bits, MSB first
  function automatic logic [3:0] crc4(input logic [11:0] msg);
    logic [3:0] c;
    logic fb;
    c = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      fb = c[3] ^ msg[i];
      c = {c[2:0], 1'b0} ^ (fb ? `CRC_POLY : 4'h0);
    end
    return c;
  endfunction

  logic [5:0] active;
  logic [11:0] msg;
  always_comb begin
    for (int n = 0; n < 6; n++) begin
      active[5 - n] = (state_q == bal_exec_pkg::ST_ON) &&
                      (run_cmd_q[11 - 2 * n -: 2] != 2'h0);
    end
  end
  assign msg = {i_health.gate_ok & active,
                i_health.cells_ok & (|active),
                i_health.sec_ok & (|active),
                i_health.temp_ok & (|active), 3'h0};

  // Status and drive outputs from flops
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_balance_status_word <= `STATUS_RESET;
      o_balance_drive <= 12'h000;
      o_balancing <= 1'b0;
    end else begin
      o_balance_status_word <= {msg, ~crc4(msg)};
      o_balance_drive <= (state_q == bal_exec_pkg::ST_ON) ? run_cmd_q : 12'h000;
      o_balancing <= (state_q == bal_exec_pkg::ST_ON);
    end
  end

  chk_pause_bad: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    byte_done && !parity_ok |=> state_q == bal_exec_pkg::ST_IDLE)
    else $error("bad parity did not pause");
  chk_exec_start: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    byte_done && parity_ok && is_exec |=> state_q == bal_exec_pkg::ST_DELAY)
    else $error("execute did not start");
  chk_exec_lock: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    byte_done && is_exec |=> locked_q)
    else $error("execute did not lock port");
  chk_lock_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    locked_q && !cs_n |=> locked_q)
    else $error("lock dropped early");
  chk_idle_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_q == bal_exec_pkg::ST_IDLE |=> !o_balancing)
    else $error("balancing while paused");
  chk_delay_wait: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(state_q == bal_exec_pkg::ST_ON) |-> $past(state_q) == bal_exec_pkg::ST_DELAY
    && dly_q == 32'(START_DELAY_CYC - 1))
    else $error("start delay not respected");
  chk_crc_inv: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ##1 o_balance_status_word[3:0] == ~crc4(o_balance_status_word[15:4]))
    else $error("status CRC wrong");
  chk_gate_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_balancing |-> o_balance_status_word[15:7] == 9'h000)
    else $error("status high while inactive");

  // Steps of a start: a good execute byte, then a fresh delay count
  sequence s_good_exec;
    byte_done && parity_ok && is_exec;
  endsequence
  sequence s_delay_start;
    state_q == bal_exec_pkg::ST_DELAY && dly_q == 32'h0;
  endsequence

  chk_resume_fresh: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    s_good_exec |=> s_delay_start)
    else $error("delay count not restarted");
  chk_pause_keep: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    state_q == bal_exec_pkg::ST_IDLE && !(byte_done && parity_ok && is_exec)
    |=> state_q == bal_exec_pkg::ST_IDLE)
    else $error("pause left without execute");
  chk_drive_off: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !o_balancing |-> o_balance_drive == 12'h000)
    else $error("drive active while paused");
  chk_lock_free: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    cs_n |=> !locked_q)
    else $error("lock kept after deselect");
  chk_zero_bits: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_balance_status_word[6:4] == 3'h0)
    else $error("unused status bits set");
endmodule
`default_nettype wire

// file: sim/host_model.sv
// Host side model of the serial port
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Bench clock, pins change on its falling edge
  input wire logic i_clk,
  // Serial pins toward the device
  output logic o_cs_n,
  output logic o_sck,
  output logic o_sdi
);
  // Clock stands low outside frames
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_sdi = 1'b0;
  end
  // Frame of n bytes, MSB first, 200 ns per bit; data flips once released
  task automatic send(input logic [15:0] b, input int n);
    @(negedge i_clk) o_cs_n = 1'b0;
    for (int i = 15; i > 15 - 8 * n; i--) begin
      o_sdi = b[i];
      repeat (4) @(negedge i_clk);
      o_sck = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sck = 1'b0;
    end
    repeat (8) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    repeat (8) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

// file: sim/tb.sv
// Bench for execute, pause, resume and the status word
`include "bal_exec_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 0, rst_n = 0, cs_n, sck, sdi, bal;
  logic [11:0] cmd = '0, drive;
  logic [15:0] stat;
  bal_exec_pkg::health_s hl = '0;
  int error_cnt = 0, check_count = 0, cyc = 0;
  always #12.5 clk = ~clk;
  host_model HOST (.i_clk(clk), .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi));
  balance_execute_pause_status #(.START_DELAY_CYC(200)) DUT (.i_clk(clk), .i_rst_n(rst_n),
    .i_chip_select_in_n(cs_n), .i_serial_clock_in(sck), .i_serial_data_in(sdi),
    .i_held_cmd(cmd), .i_held_valid(1'b1), .i_health(hl), .o_balance_drive(drive),
    .o_balancing(bal), .o_balance_status_word(stat));
  // Status word: gated health bits, zeros, inverted CRC-4 over 12 bits
  function automatic logic [15:0] exp_st(logic [11:0] d, bal_exec_pkg::health_s h);
    logic [5:0] a;
    logic [11:0] m;
    logic [3:0] c;
    c = 4'h0;
    for (int i = 0; i < 6; i++) a[5-i] = |d[11-2*i -: 2];
    m = {h.gate_ok & a, {h.cells_ok, h.sec_ok, h.temp_ok} & {3{|a}}, 3'h0};
    for (int i = 11; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ m[i]) ? 4'h3 : 4'h0);
    return {m, ~c};
  endfunction
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  // Bounded wait for the balancing level
  task automatic wait_bal(logic v);
    for (int n = 0; n < 300 && bal !== v; n++) @(negedge clk);
    chk("balancing", {15'h0, v}, {15'h0, bal});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report;
    end
  end
  initial begin
    cmd = $urandom(5);
    repeat (2) @(negedge clk);
    chk("status_rst", `STATUS_RESET, stat);
    rst_n = 1;
    repeat (4) @(negedge clk);
    for (int t = 0; t < 4; t++) begin
      // First pass is the all-on corner
      cmd = (t == 0) ? 12'hFFF : (12'($urandom) | 12'h400);
      hl = (t == 0) ? 9'h1FF : 9'($urandom);
      // Bad-parity byte after execute in one frame must be ignored
      HOST.send({`CMD_EXEC_GOOD, 8'h01}, 2);
      chk("on_early", 16'h0, {15'h0, bal});
      wait_bal(1);
      chk("drive", {4'h0, cmd}, {4'h0, drive});
      chk("status_on", exp_st(cmd, hl), stat);
      HOST.send({`CMD_EXEC_BAD, 8'h00}, 1);
      wait_bal(0);
      chk("status_off", exp_st(12'h0, hl), stat);
      // Good-parity read byte must leave the pause in place
      HOST.send(16'hAC00, 1);
      wait_bal(0);
      HOST.send({`CMD_EXEC_GOOD, 8'h00}, 1);
      wait_bal(1);
      chk("drive_res", {4'h0, cmd}, {4'h0, drive});
      HOST.send(16'h0100, 1);
      wait_bal(0);
      chk("drive_off", 16'h0, {4'h0, drive});
      $display("test %0d done", t);
    end
    final_report;
  end
endmodule
`default_nettype wire
